// [src/sdh_datapath_cfg.sv]
/*
 * Card host configuration and data path: APB registers, command launch,
 * byte transfer on 1, 4 or 8 lanes in block chunks, a remaining-byte count,
 * sticky events on one interrupt.
 * Assumes a card clock far slower than mclk and a FIFO side that sinks every
 * received word at once (no receive back-pressure).
 */
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
// Operation
// - Data bus width 1, 4 or 8
// - Transmit side accepts sized words
// - Receive side delivers sized words
// - Enable zero holds interface inoperative
// - Block length is two to exponent
// - Long transfers split into block chunks
// - Exact byte count, then completion event
// - Size field reads remaining bytes
// - Go bit starts; direction picks read/write
// - Argument sent with next command
// - Argument reads back as written
// - Command write launches command frame
module sdh_datapath_cfg (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// APB slave
	input wire sdh_pkg::sdh_apb_req_t apbReq,
	output sdh_pkg::sdh_apb_rsp_t apbRsp,
	// Interrupt
	output logic irq,
	// Card pins
	input wire logic cardClk,
	input wire logic cmdIn,
	output logic cmdOut,
	output logic cmdOe,
	input wire logic [7:0] datIn,
	output logic [7:0] datOut,
	output logic [7:0] datOe,
	// Transmit FIFO side
	input wire logic [63:0] txData,
	input wire logic txValid,
	output logic txReady,
	// Receive FIFO side
	output logic [63:0] rxData,
	output logic rxValid
);
	import sdh_pkg::*;

	// Whole module state
	typedef struct packed {
		sdh_apb_rsp_t rsp;
		logic [1:0] width;
		logic [1:0] txSize;
		logic [1:0] rxSize;
		logic enable;
		logic [3:0] blkExp;
		logic [15:0] remain;
		logic go;
		logic dir;
		logic [31:0] arg;
		logic [5:0] cmdIdx;
		logic cmdLoad;
		logic cmdIssued;
		logic [SDH_EV_N-1:0] evSts;
		logic [SDH_EV_N-1:0] evMsk;
		logic irq;
		sdh_dstate_t dstate;
		logic clkPrev;
		logic [7:0] byteSh;
		logic [3:0] sliceCnt;
		logic [15:0] blkCnt;
		logic [63:0] txWord;
		logic [3:0] txLeft;
		logic txReady;
		logic [63:0] rxWord;
		logic [3:0] rxCnt;
		logic rxValid;
		logic [63:0] rxData;
		logic [7:0] datOut;
		logic [7:0] datOe;
	} sdh_st_t;

	sdh_st_t st_r; // Registered state
	sdh_st_t st_nxt; // Next state
	logic [9:0] pinSync; // Synchronised card clock, command and data lines
	logic cmdBusy; // Command frame in flight
	logic cmdDone; // Command frame finished, one cycle
	logic linkEdge; // Rising card clock edge, one cycle

	// Slices of one byte per card clock edge for a width code
	function automatic logic [3:0] slicesPerByte(input logic [1:0] w);
		unique case (w)
			SDH_W4: return 4'h2;
			SDH_W8: return 4'h1;
			default: return 4'h8; // Width one; reserved code falls back to it
		endcase
	endfunction

	// Lanes driven for a width code
	function automatic logic [7:0] laneMask(input logic [1:0] w);
		unique case (w)
			SDH_W4: return 8'h0f;
			SDH_W8: return 8'hff;
			default: return 8'h01;
		endcase
	endfunction

	// Bytes in one FIFO word for a size code
	function automatic logic [3:0] wordBytes(input logic [1:0] s);
		unique case (s)
			SDH_SZ16: return 4'h2;
			SDH_SZ32: return 4'h4;
			SDH_SZ64: return 4'h8;
			default: return 4'h1;
		endcase
	endfunction

	// Top slice of a byte placed on the low lanes
	function automatic logic [7:0] topSlice(input logic [7:0] b, input logic [1:0] w);
		unique case (w)
			SDH_W4: return {4'h0, b[7:4]};
			SDH_W8: return b;
			default: return {7'h00, b[7]};
		endcase
	endfunction

	// Shift the byte left by one slice
	function automatic logic [7:0] shiftOut(input logic [7:0] b, input logic [1:0] w);
		unique case (w)
			SDH_W4: return {b[3:0], 4'h0};
			SDH_W8: return 8'h00;
			default: return {b[6:0], 1'b0};
		endcase
	endfunction

	// Shift one sampled slice into the byte
	function automatic logic [7:0] shiftIn(input logic [7:0] b, input logic [7:0] d,
			input logic [1:0] w);
		unique case (w)
			SDH_W4: return {b[3:0], d[3:0]};
			SDH_W8: return d;
			default: return {b[6:0], d[0]};
		endcase
	endfunction

	// Pin synchroniser: clock, command and data lines
	sdh_sync #(
		.WIDTH(10)
	) uSync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.asyncIn({cardClk, cmdIn, datIn}),
		.syncOut(pinSync)
	);

	assign linkEdge = pinSync[9] & ~st_r.clkPrev;

	// Command frame sender
	sdh_cmd_shift uCmd (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.enable(st_r.enable),
		.load(st_r.cmdLoad),
		.cmdIndex(st_r.cmdIdx),
		.cmdArg(st_r.arg),
		.linkEdge(linkEdge),
		.cmdOut(cmdOut),
		.cmdOe(cmdOe),
		.busy(cmdBusy),
		.done(cmdDone)
	);

	// Register access, launch, data path and events
	always_comb begin
		logic acc;
		logic wr;
		logic [31:0] wd;
		logic [SDH_EV_N-1:0] evSet;
		logic [SDH_EV_N-1:0] evClr;
		logic [15:0] blkLen;
		logic [7:0] curByte;
		logic byteDone;
		acc = apbReq.psel & apbReq.penable & st_r.rsp.pready;
		wr = acc & apbReq.pwrite;
		wd = apbReq.pwdata;
		evSet = '0;
		evClr = '0;
		blkLen = 16'h0001 << st_r.blkExp;
		curByte = st_r.byteSh;
		byteDone = 1'b0;
		st_nxt = st_r;
		st_nxt.clkPrev = pinSync[9];
		st_nxt.cmdLoad = 1'b0;
		st_nxt.rxValid = 1'b0;
		st_nxt.rsp.pready = 1'b0;
		st_nxt.rsp.pslverr = 1'b0;

		// APB answer one cycle into the access phase
		if (apbReq.psel && apbReq.penable && !st_r.rsp.pready) begin
			st_nxt.rsp.pready = 1'b1;
			st_nxt.rsp.prdata = 32'h0000_0000;
			unique case (apbReq.paddr)
				SDH_OFF_CFG: begin
					st_nxt.rsp.prdata[SDH_CFG_W_LSB +: 2] = st_r.width;
					st_nxt.rsp.prdata[SDH_CFG_TX_LSB +: 2] = st_r.txSize;
					st_nxt.rsp.prdata[SDH_CFG_RX_LSB +: 2] = st_r.rxSize;
					st_nxt.rsp.prdata[SDH_CFG_EN_BIT] = st_r.enable;
					st_nxt.rsp.prdata[SDH_CFG_BS_LSB +: 4] = st_r.blkExp;
				end
				SDH_OFF_DCTL: begin
					st_nxt.rsp.prdata[SDH_DCTL_SIZE_LSB +: 16] = st_r.remain;
					st_nxt.rsp.prdata[SDH_DCTL_GO_BIT] = st_r.go;
					st_nxt.rsp.prdata[SDH_DCTL_DIR_BIT] = st_r.dir;
				end
				SDH_OFF_ARG: st_nxt.rsp.prdata = st_r.arg;
				SDH_OFF_CMD: st_nxt.rsp.prdata[5:0] = st_r.cmdIdx;
				SDH_OFF_ISTS: st_nxt.rsp.prdata[SDH_EV_N-1:0] = st_r.evSts;
				SDH_OFF_IMSK: st_nxt.rsp.prdata[SDH_EV_N-1:0] = st_r.evMsk;
				default: st_nxt.rsp.pslverr = 1'b1; // Unmapped address
			endcase
		end

		// Register writes at the completing edge
		if (wr) begin
			unique case (apbReq.paddr)
				SDH_OFF_CFG: begin
					st_nxt.width = wd[SDH_CFG_W_LSB +: 2];
					st_nxt.txSize = wd[SDH_CFG_TX_LSB +: 2];
					st_nxt.rxSize = wd[SDH_CFG_RX_LSB +: 2];
					st_nxt.enable = wd[SDH_CFG_EN_BIT];
					st_nxt.blkExp = wd[SDH_CFG_BS_LSB +: 4];
				end
				SDH_OFF_DCTL: begin
					// Settings frozen while a transfer runs
					if (st_r.dstate == SDH_DIDLE) begin
						st_nxt.remain = wd[SDH_DCTL_SIZE_LSB +: 16];
						st_nxt.dir = wd[SDH_DCTL_DIR_BIT];
						st_nxt.go = wd[SDH_DCTL_GO_BIT] & st_r.enable;
						st_nxt.cmdIssued = 1'b0;
					end
				end
				SDH_OFF_ARG: st_nxt.arg = wd;
				SDH_OFF_CMD: begin
					st_nxt.cmdIdx = wd[5:0];
					// Launch only when enabled and no frame in flight
					st_nxt.cmdLoad = st_r.enable & ~cmdBusy;
				end
				SDH_OFF_ISTS: evClr = wd[SDH_EV_N-1:0];
				SDH_OFF_IMSK: st_nxt.evMsk = wd[SDH_EV_N-1:0];
				default: ;
			endcase
		end

		// Command end arms the data path
		if (cmdDone) begin
			evSet[SDH_EV_CMD] = 1'b1;
			st_nxt.cmdIssued = 1'b1;
		end

		// Transmit word intake
		if (txValid && st_r.txReady) begin
			st_nxt.txWord = txData;
			st_nxt.txLeft = wordBytes(st_r.txSize);
		end

		// Data path sequencer
		unique case (st_r.dstate)
			SDH_DIDLE: begin
				// Last slice stands one card clock before release
				if (linkEdge) st_nxt.datOe = 8'h00;
				if (st_r.go && st_r.cmdIssued && st_r.enable) begin
					st_nxt.cmdIssued = 1'b0;
					st_nxt.blkCnt = 16'h0000;
					st_nxt.sliceCnt = 4'h0;
					st_nxt.rxCnt = 4'h0;
					if (st_r.remain == 16'h0000) begin
						// Nothing to move: complete at once
						st_nxt.go = 1'b0;
						evSet[SDH_EV_DATA] = 1'b1;
					end else begin
						st_nxt.dstate = SDH_DSTART;
					end
				end
			end
			SDH_DSTART: begin
				if (linkEdge) begin
					if (st_r.dir) begin
						// Start bit on every used lane
						st_nxt.datOut = 8'h00;
						st_nxt.datOe = laneMask(st_r.width);
						st_nxt.dstate = SDH_DRUN;
					end else if (!pinSync[0]) begin
						// Card start bit seen on lane zero
						st_nxt.dstate = SDH_DRUN;
					end
				end
			end
			SDH_DRUN: begin
				if (linkEdge && st_r.dir) begin
					// Write: stall at a byte boundary until a word is held
					if (st_r.sliceCnt != 4'h0 || st_r.txLeft != 4'h0) begin
						if (st_r.sliceCnt == 4'h0) begin
							curByte = st_r.txWord[7:0];
							st_nxt.txWord = {8'h00, st_r.txWord[63:8]};
							st_nxt.txLeft = st_r.txLeft - 4'h1;
							st_nxt.sliceCnt = slicesPerByte(st_r.width) - 4'h1;
						end else begin
							st_nxt.sliceCnt = st_r.sliceCnt - 4'h1;
						end
						st_nxt.datOut = topSlice(curByte, st_r.width);
						st_nxt.byteSh = shiftOut(curByte, st_r.width);
						byteDone = (st_nxt.sliceCnt == 4'h0);
					end
				end else if (linkEdge) begin
					// Read: one slice per edge into the byte
					st_nxt.byteSh = shiftIn(st_r.byteSh, pinSync[7:0], st_r.width);
					st_nxt.sliceCnt = (st_r.sliceCnt == 4'h0) ?
						slicesPerByte(st_r.width) - 4'h1 : st_r.sliceCnt - 4'h1;
					byteDone = (st_nxt.sliceCnt == 4'h0);
					if (byteDone) begin
						st_nxt.rxWord[st_r.rxCnt[2:0]*8 +: 8] = st_nxt.byteSh;
						st_nxt.rxCnt = st_r.rxCnt + 4'h1;
					end
				end
				if (byteDone) begin
					st_nxt.remain = st_r.remain - 16'h0001;
					// Block chunk boundary
					if (st_r.blkCnt == blkLen - 16'h0001) begin
						st_nxt.blkCnt = 16'h0000;
						evSet[SDH_EV_BLK] = 1'b1;
					end else begin
						st_nxt.blkCnt = st_r.blkCnt + 16'h0001;
					end
					if (st_r.remain == 16'h0001) begin
						// Last byte: end transfer and flag completion
						st_nxt.dstate = SDH_DIDLE;
						st_nxt.go = 1'b0;
						evSet[SDH_EV_DATA] = 1'b1;
					end
				end
			end
			default: st_nxt.dstate = SDH_DIDLE;
		endcase

		// Receive word out when full, or partial at the end
		if (st_nxt.rxCnt == wordBytes(st_r.rxSize) ||
				(st_nxt.dstate == SDH_DIDLE && st_nxt.rxCnt != 4'h0)) begin
			st_nxt.rxData = st_nxt.rxWord;
			st_nxt.rxValid = 1'b1;
			st_nxt.rxWord = 64'h0;
			st_nxt.rxCnt = 4'h0;
		end

		// Disabled: stop the data path, keep the count
		if (!st_r.enable) begin
			st_nxt.dstate = SDH_DIDLE;
			st_nxt.datOe = 8'h00;
		end

		// Ask for a word only while a write runs with none held
		st_nxt.txReady = st_r.enable && st_nxt.dstate != SDH_DIDLE && st_r.dir &&
			st_nxt.txLeft == 4'h0 && !(txValid && st_r.txReady);

		// Sticky events: a set in the clearing cycle wins
		st_nxt.evSts = (st_r.evSts & ~evClr) | evSet;
		st_nxt.irq = |(st_nxt.evSts & st_nxt.evMsk);
	end

	// State register with reset values
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_r <= '0;
			st_r.width <= SDH_RST_CODE2;
			st_r.txSize <= SDH_RST_CODE2;
			st_r.rxSize <= SDH_RST_CODE2;
			st_r.blkExp <= SDH_RST_BS;
			st_r.remain <= SDH_RST_SIZE;
			st_r.arg <= SDH_RST_ARG;
			st_r.cmdIdx <= SDH_RST_IDX;
			st_r.evSts <= SDH_RST_EV;
			st_r.evMsk <= SDH_RST_EV;
			st_r.dstate <= SDH_DIDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register
	assign apbRsp = st_r.rsp;
	assign irq = st_r.irq;
	assign datOut = st_r.datOut;
	assign datOe = st_r.datOe;
	assign txReady = st_r.txReady;
	assign rxData = st_r.rxData;
	assign rxValid = st_r.rxValid;

endmodule // sdh_datapath_cfg

// [common/sdh_pkg.sv]
/*
 * Constants and carrier types of the card host data path block:
 * offsets, field positions, reset values, codes, states.
 * Assumes a 32-bit APB bus and eight card data lanes.
 */
package sdh_pkg;

	// Register byte offsets
	localparam logic [11:0] SDH_OFF_CFG = 12'h010; // Card interface configuration
	localparam logic [11:0] SDH_OFF_DCTL = 12'h014; // Data path control
	localparam logic [11:0] SDH_OFF_ARG = 12'h018; // Command argument
	localparam logic [11:0] SDH_OFF_CMD = 12'h01c; // Command index, write launches
	localparam logic [11:0] SDH_OFF_ISTS = 12'h040; // Sticky event status, write one to clear
	localparam logic [11:0] SDH_OFF_IMSK = 12'h044; // Event mask, one passes the event

	// Configuration field positions
	localparam int SDH_CFG_BS_LSB = 0; // Block size exponent, 4 bits
	localparam int SDH_CFG_EN_BIT = 5; // Global enable
	localparam int SDH_CFG_RX_LSB = 6; // Receive word size, 2 bits
	localparam int SDH_CFG_TX_LSB = 8; // Transmit word size, 2 bits
	localparam int SDH_CFG_W_LSB = 12; // Data bus width, 2 bits

	// Data path control field positions
	localparam int SDH_DCTL_DIR_BIT = 0; // Zero reads the card, one writes it
	localparam int SDH_DCTL_GO_BIT = 1; // Data path go
	localparam int SDH_DCTL_SIZE_LSB = 16; // Byte count, 16 bits

	// Event bit positions in status and mask
	localparam int SDH_EV_CMD = 0; // Command frame sent
	localparam int SDH_EV_DATA = 1; // Data transfer complete
	localparam int SDH_EV_BLK = 2; // One block finished
	localparam int SDH_EV_N = 3;

	// Reset values
	localparam logic [31:0] SDH_RST_ARG = 32'h0000_0000;
	localparam logic [1:0] SDH_RST_CODE2 = 2'h0;
	localparam logic [3:0] SDH_RST_BS = 4'h0;
	localparam logic [15:0] SDH_RST_SIZE = 16'h0000;
	localparam logic [5:0] SDH_RST_IDX = 6'h00;
	localparam logic [SDH_EV_N-1:0] SDH_RST_EV = 3'h0;

	// Data bus width codes
	localparam logic [1:0] SDH_W1 = 2'h0;
	localparam logic [1:0] SDH_W4 = 2'h1;
	localparam logic [1:0] SDH_W8 = 2'h2;

	// FIFO word size codes
	localparam logic [1:0] SDH_SZ8 = 2'h0;
	localparam logic [1:0] SDH_SZ16 = 2'h1;
	localparam logic [1:0] SDH_SZ32 = 2'h2;
	localparam logic [1:0] SDH_SZ64 = 2'h3;

	// Command frame layout
	localparam int SDH_FRAME_BITS = 48; // Start, direction, index, argument, check, end
	localparam logic [6:0] SDH_CRC_POLY = 7'h09; // x^7 + x^3 + 1
	localparam logic [1:0] SDH_FRAME_HEAD = 2'h1; // Start bit zero, host direction one
	localparam logic SDH_FRAME_END = 1'b1;

	// Data path states, Gray along idle, start, run
	typedef enum logic [1:0] {
		SDH_DIDLE = 2'b00,
		SDH_DSTART = 2'b01,
		SDH_DRUN = 2'b11
	} sdh_dstate_t;

	// APB request as one carrier
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} sdh_apb_req_t;

	// APB answer
	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} sdh_apb_rsp_t;

	// State of the command shifter
	typedef struct packed {
		logic [SDH_FRAME_BITS-1:0] sh;
		logic [5:0] cnt;
		logic busy;
		logic out;
		logic oe;
		logic done;
	} sdh_cmd_st_t;

endpackage

// [src/sdh_sync.sv]
/*
 * Two flip-flop synchroniser for a group of level inputs.
 * Assumes slow levels; bits are not kept coherent.
 */
`timescale 1ns/100ps
module sdh_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Asynchronous inputs and their synchronised copies
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_r; // First stage, read only by the second
	logic [WIDTH-1:0] stage2_r; // Second stage, safe to use

	// Two stages in series
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			stage1_r <= '0;
			stage2_r <= '0;
		end else begin
			stage1_r <= asyncIn;
			stage2_r <= stage1_r;
		end
	end

	assign syncOut = stage2_r;

endmodule // sdh_sync

// [src/sdh_cmd_shift.sv]
/*
 * Command frame shifter: index and argument into a 48-bit frame
 * with its seven-bit check, sent one bit per card clock edge.
 * Assumes at most one edge pulse per card clock period.
 */
`timescale 1ns/100ps
module sdh_cmd_shift (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Control from the register side
	input wire logic enable,
	input wire logic load,
	input wire logic [5:0] cmdIndex,
	input wire logic [31:0] cmdArg,
	input wire logic linkEdge,
	// Command line and status
	output logic cmdOut,
	output logic cmdOe,
	output logic busy,
	output logic done
);
	import sdh_pkg::*;

	sdh_cmd_st_t st_r; // All state
	sdh_cmd_st_t st_nxt; // Next state

	// Seven-bit check over the first 40 frame bits
	function automatic logic [6:0] crc7(input logic [39:0] bits);
		logic [6:0] c;
		logic fb;
		c = 7'h00;
		for (int i = 39; i >= 0; i--) begin
			fb = bits[i] ^ c[6];
			c = {c[5:0], 1'b0} ^ (fb ? SDH_CRC_POLY : 7'h00);
		end
		return c;
	endfunction

	// Next-state logic
	always_comb begin
		logic [39:0] head;
		head = {SDH_FRAME_HEAD, cmdIndex, cmdArg};
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		if (!enable) begin
			// Interface held inoperative: drop any frame
			st_nxt.busy = 1'b0;
			st_nxt.oe = 1'b0;
			st_nxt.cnt = '0;
		end else if (load && !st_r.busy) begin
			// Capture the argument as it stands now
			st_nxt.sh = {head, crc7(head), SDH_FRAME_END};
			st_nxt.cnt = 6'(SDH_FRAME_BITS);
			st_nxt.busy = 1'b1;
		end else if (linkEdge && st_r.busy) begin
			if (st_r.cnt != '0) begin
				// Next bit out, most significant first
				st_nxt.out = st_r.sh[SDH_FRAME_BITS-1];
				st_nxt.oe = 1'b1;
				st_nxt.sh = {st_r.sh[SDH_FRAME_BITS-2:0], 1'b0};
				st_nxt.cnt = st_r.cnt - 6'h01;
			end else begin
				// End bit has stood one period: release the line
				st_nxt.oe = 1'b0;
				st_nxt.out = 1'b0;
				st_nxt.busy = 1'b0;
				st_nxt.done = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cmdOut = st_r.out;
	assign cmdOe = st_r.oe;
	assign busy = st_r.busy;
	assign done = st_r.done;

endmodule // sdh_cmd_shift

// [sim/sdh_dpc_sva.sv]
/* Port checks of the card host data path.
   Assumes a card clock of 16 mclk periods. */
`timescale 1ns/100ps
module sdh_dpc_sva (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Register bus
	input wire sdh_pkg::sdh_apb_req_t apbReq,
	input wire sdh_pkg::sdh_apb_rsp_t apbRsp,
	// Link and stream outputs
	input wire logic cmdOut,
	input wire logic cmdOe,
	input wire logic [7:0] datOe,
	input wire logic txReady,
	input wire logic rxValid
);
	import sdh_pkg::*;
	localparam int FRAME_MIN = 760; // 48 bits of 16 mclk, less sync jitter
	localparam int FRAME_MAX = 776; // Same, plus jitter
	logic [31:0] cfgR; // Shadow of the written configuration
	logic [31:0] argR; // Shadow of the written argument
	logic [15:0] oeCnt; // Command enable cycles
	logic wrDone; // Write completes
	logic mapped; // Address hits a register
	logic [7:0] laneM; // Allowed lanes
	assign wrDone = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite;
	assign mapped = apbReq.paddr inside {SDH_OFF_CFG, SDH_OFF_DCTL, SDH_OFF_ARG,
		SDH_OFF_CMD, SDH_OFF_ISTS, SDH_OFF_IMSK};
	assign laneM = (cfgR[13:12] == SDH_W8) ? 8'hff : (cfgR[13:12] == SDH_W4) ? 8'h0f : 8'h01;
	// Write shadows and command enable count
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cfgR <= 32'h0;
			argR <= 32'h0;
			oeCnt <= 16'h0;
		end else begin
			if (wrDone && apbReq.paddr == SDH_OFF_CFG) cfgR <= apbReq.pwdata;
			if (wrDone && apbReq.paddr == SDH_OFF_ARG) argR <= apbReq.pwdata;
			oeCnt <= cmdOe ? oeCnt + 16'h1 : 16'h0;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// Start bit held low, then the host direction bit high
	sequence sStart;
		!cmdOut [*8];
	endsequence
	sequence sFrame;
		sStart ##[1:12] cmdOut;
	endsequence
	a_ready_wait: assert property (
		apbReq.psel && apbReq.penable && !apbRsp.pready |=> apbRsp.pready)
		else $error("late bus answer");
	a_err_map: assert property (
		apbRsp.pready |-> apbRsp.pslverr == !mapped)
		else $error("bad error flag");
	a_arg_read: assert property (
		apbRsp.pready && !apbReq.pwrite && apbReq.paddr == SDH_OFF_ARG |-> apbRsp.prdata == argR)
		else $error("bad argument read");
	a_cfg_read: assert property (
		apbRsp.pready && !apbReq.pwrite && apbReq.paddr == SDH_OFF_CFG
		|-> apbRsp.prdata == (cfgR & 32'h0000_33ef))
		else $error("bad config read");
	a_idle_off: assert property (
		!cfgR[SDH_CFG_EN_BIT] && !$past(cfgR[SDH_CFG_EN_BIT])
		|-> !cmdOe && datOe == 8'h00 && !txReady)
		else $error("link active while disabled");
	a_cmd_frame: assert property ($rose(cmdOe) |-> sFrame)
		else $error("bad frame head");
	a_cmd_len: assert property (
		$fell(cmdOe) |-> oeCnt >= FRAME_MIN && oeCnt <= FRAME_MAX)
		else $error("bad frame length");
	a_lane_mask: assert property ((datOe & ~laneM) == 8'h00)
		else $error("lane outside width");
	a_rx_pulse: assert property (rxValid |=> !rxValid)
		else $error("long receive strobe");
endmodule // sdh_dpc_sva

bind sdh_datapath_cfg sdh_dpc_sva chk_u (.mclk(mclk), .sys_rst(sys_rst), .apbReq(apbReq),
	.apbRsp(apbRsp), .cmdOut(cmdOut), .cmdOe(cmdOe), .datOe(datOe), .txReady(txReady),
	.rxValid(rxValid));

// [sim/sdh_card_model.sv]
/* Memory card: logs command frames and written bytes, reads back a counting pattern.
   Assumes the bench runs the card clock. */
`timescale 1ns/100ps
module sdh_card_model (
	// Link clock and host pins
	input wire logic cardClk,
	input wire logic cmdOut,
	input wire logic cmdOe,
	input wire logic [7:0] datOut,
	input wire logic [7:0] datOe,
	// Bench controls
	input wire logic [1:0] laneW,
	input wire logic [15:0] rdLen,
	// Card data lines and logs
	output logic [7:0] datIn,
	output logic [47:0] frame,
	output int frameCnt,
	output logic [63:0] wrLog,
	output int wrN
);
	logic [47:0] sh; // Command bits so far
	logic [7:0] acc, tx; // Write byte gathered, read byte being sent
	logic inWr, sendPend, sending; // Transfer phases
	int cnt, bits, nb, sb, sent; // Counters; nb is lanes in use
	assign nb = (laneW == 2'h2) ? 8 : (laneW == 2'h1) ? 4 : 1;
	initial begin
		{sh, acc, tx, inWr, sendPend, sending, frame, wrLog} = '0;
		{cnt, bits, sb, sent, frameCnt, wrN} = '0;
		datIn = 8'hff;
	end
	// Card samples on the rising edge
	always @(posedge cardClk) begin
		if (cmdOe === 1'b1) begin
			sh = {sh[46:0], cmdOut};
			cnt++;
		end else if (cnt > 0) begin
			frame = sh;
			frameCnt++;
			cnt = 0;
			sendPend = (rdLen != 16'h0);
		end
		if (datOe[0] !== 1'b1) inWr = 1'b0;
		else if (!inWr) begin
			inWr = (datOut[0] === 1'b0);
			bits = 0;
		end else begin
			acc = (acc << nb) | (datOut & 8'((1 << nb) - 1));
			bits += nb;
			if (bits == 8) begin
				wrLog = {wrLog[55:0], acc};
				wrN++;
				bits = 0;
			end
		end
	end
	// Card drives on the falling edge
	always @(negedge cardClk) begin
		if (sendPend) begin
			datIn = ~8'((1 << nb) - 1); // Start bit on used lanes
			{sendPend, sending, sent, sb, tx} = {1'b0, 1'b1, 32'h0, 32'h0, 8'h00};
		end else if (sending && sent == int'(rdLen)) begin
			datIn = 8'hff; // Released: pull-ups
			sending = 1'b0;
		end else if (sending) begin
			datIn = ~8'((1 << nb) - 1) | 8'(tx >> (8 - nb)); // MSB slice first
			tx = tx << nb;
			sb += nb;
			if (sb == 8) begin
				sb = 0;
				sent++;
				tx = 8'(sent);
			end
		end
	end
endmodule // sdh_card_model

// [sim/sdh_datapath_cfg_tb.sv]
/* Bench of the card host data path.
   Assumes the card model and the bound checker. */
`timescale 1ns/100ps
module sdh_datapath_cfg_tb;
	import sdh_pkg::*;
	logic mclk, sys_rst, cardClk, clkRun, txValid; // Clocks and controls
	sdh_apb_req_t apbReq; // Bus request
	sdh_apb_rsp_t apbRsp; // Bus answer
	logic irq, cmdOut, cmdOe, txReady, rxValid, e; // Design outputs, last bus error
	logic [7:0] datIn, datOut, datOe; // Data lanes
	logic [63:0] txData, rxData, wrLog; // Stream words, card write log
	logic [63:0] rxW [8]; // Received words
	logic [47:0] frame; // Last frame seen by the card
	logic [31:0] q; // Last read data
	logic [1:0] laneW; // Width told to the card
	logic [15:0] rdLen; // Bytes the card answers with
	int frameCnt, wrN, rxN, cyc, num_errors, samples_checked;
	sdh_datapath_cfg dut_u (.mclk(mclk), .sys_rst(sys_rst), .apbReq(apbReq), .apbRsp(apbRsp),
		.irq(irq), .cardClk(cardClk), .cmdIn(1'b1), .cmdOut(cmdOut), .cmdOe(cmdOe),
		.datIn(datIn), .datOut(datOut), .datOe(datOe), .txData(txData), .txValid(txValid),
		.txReady(txReady), .rxData(rxData), .rxValid(rxValid));
	sdh_card_model mdl_u (.cardClk(cardClk), .cmdOut(cmdOut), .cmdOe(cmdOe), .datOut(datOut),
		.datOe(datOe), .laneW(laneW), .rdLen(rdLen), .datIn(datIn), .frame(frame),
		.frameCnt(frameCnt), .wrLog(wrLog), .wrN(wrN));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Card clock, unrelated in phase, still while idle
	initial begin
		cardClk = 1'b0;
		#37;
		forever #80 cardClk = clkRun & ~cardClk;
	end
	// Hang guard and receive capture
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			wrap_up;
		end
		if (rxValid === 1'b1) begin
			rxW[rxN[2:0]] = rxData;
			rxN++;
		end
	end
	task wrap_up;
		$display("Checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One bus transfer
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge mclk);
		apbReq.penable <= 1'b1;
		do @(posedge mclk);
		while (apbRsp.pready !== 1'b1);
		q = apbRsp.prdata;
		e = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask
	task waitEv(input int b);
		do apb(1'b0, SDH_OFF_ISTS, 32'h0);
		while (q[b] !== 1'b1);
		repeat (40) @(posedge mclk);
	endtask
	task feedTx(input logic [63:0] w);
		@(posedge mclk);
		txData <= w;
		txValid <= 1'b1;
		do @(posedge mclk);
		while (txReady !== 1'b1);
		txValid <= 1'b0;
	endtask
	task t_reset;
		apb(1'b0, SDH_OFF_CFG, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, SDH_OFF_ARG, 32'h0);
		chk(q, SDH_RST_ARG);
		apb(1'b1, 12'h030, 32'hffff_ffff);
		chk(e, 1'b1);
		apb(1'b0, 12'h030, 32'h0);
		chk({e, q}, {1'b1, 32'h0});
	endtask
	task t_regs;
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, SDH_OFF_CFG, 32'hffff_c01f | (c << 12) | (c << 8) | (c << 6));
			apb(1'b0, SDH_OFF_CFG, 32'h0);
			chk(q, (c << 12) | (c << 8) | (c << 6) | 32'hf);
		end
		apb(1'b1, SDH_OFF_ARG, 32'h5a3c_96e1);
		apb(1'b0, SDH_OFF_ARG, 32'h0);
		chk(q, 32'h5a3c_96e1);
	endtask
	task t_off;
		int f;
		f = frameCnt;
		clkRun = 1'b1;
		apb(1'b1, SDH_OFF_CFG, 32'h0);
		apb(1'b1, SDH_OFF_DCTL, 32'h0008_0003);
		apb(1'b1, SDH_OFF_CMD, 32'h0000_0011);
		repeat (1000) @(posedge mclk);
		apb(1'b0, SDH_OFF_DCTL, 32'h0);
		chk(q, 32'h0008_0001);
		apb(1'b0, SDH_OFF_ISTS, 32'h0);
		chk({frameCnt - f, q}, 64'h0);
		clkRun = 1'b0;
	endtask
	task t_cmd;
		int f;
		f = frameCnt;
		clkRun = 1'b1;
		apb(1'b1, SDH_OFF_CFG, 32'h0000_0020);
		apb(1'b1, SDH_OFF_IMSK, 32'h0);
		apb(1'b1, SDH_OFF_ARG, 32'hc35a_0f69);
		apb(1'b1, SDH_OFF_CMD, 32'h0000_002d);
		waitEv(SDH_EV_CMD);
		chk({irq, frameCnt - f}, 33'h1);
		chk(frame & ~48'hfe, {2'h1, 6'h2d, 32'hc35a_0f69, 8'h01});
		apb(1'b1, SDH_OFF_IMSK, 32'h1 << SDH_EV_CMD);
		apb(1'b0, SDH_OFF_ISTS, 32'h0);
		chk(irq, 1'b1);
		apb(1'b1, SDH_OFF_ISTS, 32'h1 << SDH_EV_CMD);
		apb(1'b0, SDH_OFF_ISTS, 32'h0);
		chk({irq, q[2:0]}, 4'h0);
		clkRun = 1'b0;
	endtask
	// Four lanes, two 16-bit words, 2-byte blocks
	task t_write;
		int f;
		f = wrN;
		laneW = SDH_W4;
		clkRun = 1'b1;
		apb(1'b1, SDH_OFF_CFG, 32'h0000_1121);
		apb(1'b1, SDH_OFF_DCTL, 32'h0004_0003);
		apb(1'b1, SDH_OFF_CMD, 32'h0000_0018);
		feedTx(64'h0000_0000_0000_b2a1);
		feedTx(64'h0000_0000_0000_d4c3);
		waitEv(SDH_EV_DATA);
		chk(q[2:1], 2'b11);
		chk({wrN - f, wrLog[31:0]}, {32'd4, 32'ha1b2_c3d4});
		apb(1'b0, SDH_OFF_DCTL, 32'h0);
		chk(q, 32'h0000_0001);
		apb(1'b1, SDH_OFF_ISTS, 32'h7);
		clkRun = 1'b0;
	endtask
	// Eight lanes, 32-bit words, count read mid-run
	task t_read;
		rxN = 0;
		laneW = SDH_W8;
		rdLen = 16'd8;
		clkRun = 1'b1;
		apb(1'b1, SDH_OFF_CFG, 32'h0000_20a2);
		apb(1'b1, SDH_OFF_DCTL, 32'h0008_0002);
		apb(1'b1, SDH_OFF_CMD, 32'h0000_0012);
		while (rxN < 1) @(posedge mclk);
		apb(1'b0, SDH_OFF_DCTL, 32'h0);
		chk(q[31:16], 16'd4);
		waitEv(SDH_EV_DATA);
		chk(rxN, 2);
		chk({rxW[1][31:0], rxW[0][31:0]}, 64'h0706_0504_0302_0100);
		rdLen = 16'h0;
		clkRun = 1'b0;
	endtask
	initial begin
		{sys_rst, clkRun, txValid, apbReq, txData, laneW, rdLen} = '0;
		sys_rst = 1'b1;
		{rxN, cyc, num_errors, samples_checked} = '0;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset;
		t_regs;
		t_off;
		t_cmd;
		t_write;
		t_read;
		wrap_up;
	end
endmodule // sdh_datapath_cfg_tb
